/* File: common/sfm_defines.vh */
/*
 * Constants for the sample buffer block: register addresses, field
 * positions, mode codes, depths and fixed status values.
 * Assumes it is included once per design file by its bare name.
 */
`ifndef SFM_DEFINES_VH
`define SFM_DEFINES_VH

// Register addresses (6-bit serial register space)
`define SFM_ADDR_ROUTE      6'h22
`define SFM_ADDR_ENABLE     6'h24
`define SFM_ADDR_OUT_FIRST  6'h28
`define SFM_ADDR_OUT_LAST   6'h2D
`define SFM_ADDR_MODE       6'h2E
`define SFM_ADDR_STATUS     6'h2F
`define SFM_ADDR_GEN_CFG    6'h30
`define SFM_ADDR_EVT_SRC    6'h31

// Field positions
`define SFM_BIT_BUF_EN      6
`define SFM_BIT_RT_OVR      1
`define SFM_BIT_RT_WTM      2
`define SFM_BIT_PICK        5
`define SFM_BIT_IA          6
`define SFM_BIT_CMD_RD      7
`define SFM_BIT_CMD_INC     6

// Buffer mode field codes
`define SFM_MODE_BYPASS     2'h0
`define SFM_MODE_FILL       2'h1
`define SFM_MODE_STREAM     2'h2
`define SFM_MODE_TRIG       2'h3

// Depth and fixed values
`define SFM_SLOTS           6'h20
`define SFM_FSS_FULL        5'h1F
`define SFM_STATUS_BYPASS   8'h20
`define SFM_IA_CLR_PERIODS  2'h2
`define SFM_SET_BITS        48

`endif

/* File: hw/sfm_top.v */
/*
 * Sample buffer with mode control: a 32-slot store of 6-byte sample sets
 * running bypass, fill-then-stop, circular and circular-until-trigger
 * modes, a serial register slave, and a staging FIFO on the sample path.
 * Assumes sample ticks, sample data and generator bits come from logic on
 * i_clk_sys; the serial pins come from outside and are synchronised here.
 */
`timescale 1ns/1ps
`include "sfm_defines.vh"

////////////////////////////////////////////////////////////////////////////
// Staging FIFO: valid/ready on both sides, count based full and empty
module sfm_stage_fifo #(
  parameter WIDTH = 48,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_clk_sys,
  input  wire             i_rst_n,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];   // Storage words
  reg [AW-1:0]    wp;                // Write index
  reg [AW-1:0]    rp;                // Read index
  reg [AW:0]      cnt;               // Words held
  wire            push;
  wire            pop;

  assign o_in_ready  = (cnt != DEPTH[AW:0]);
  assign o_out_valid = (cnt != {(AW+1){1'b0}});
  assign o_out_data  = mem[rp];
  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;

  // Storage write; no reset needed for data
  always @(posedge i_clk_sys) begin
    if (push) begin
      mem[wp] <= i_in_data;
    end
  end

  // Pointers and occupancy
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp  <= {AW{1'b0}};
      rp  <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp <= (wp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
      end
      cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1 - Fill mode stores until 32, then holds
// RL2 - Enable alone freezes outputs at last set
// RL3 - Mode field picks bypass, fill, circular, trigger
// RL4 - Full fill mode status reads 0xDF
// RL5 - Overrun drives pin only when routed
// RL6 - Fill mode flags overrun at 32, stops until bypass
// RL7 - Readout oldest first, six bytes per set
// RL8 - Overrun flag clears after first set read
// RL9 - Bypass resets buffer; host bypasses before restart
// RL10 - Circular mode overwrites oldest once full
// RL11 - Host reads whole buffer within one period
// RL12 - Circular mode writes one set per tick
// RL13 - Read copies output, then shifts oldest in
// RL14 - Trigger mode circulates, freezes on trigger
// RL15 - Pick bit selects generator one or two
// RL16 - Trigger from active bit, routing irrelevant
// RL17 - Freeze needs active bit and overrun together
// RL18 - Level trigger; dropping bit resumes circulation
// RL19 - Source read clears active bit two ticks later
// RL20 - Full at trigger: one more set, then stop
// RL21 - Trigger before full: fill, then stop
// RL22 - Host should latch the trigger interrupt
// RL23 - Watermark flag when unread exceeds level
// RL24 - Bypass clears buffer, status reads 0x20
// RL25 - Count tracks unread sets both ways
// RL26 - Simultaneous write and read keep count
module sfm_top #(
  parameter STAGE_DEPTH = 16,
  parameter STAGE_AW    = 4
) (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire        i_sample_rate_tick,
  input  wire        i_sample_valid,
  output wire        o_sample_ready,
  input  wire [47:0] i_sample_data,
  input  wire        i_gen1_event,
  input  wire        i_gen2_active,
  input  wire        i_spi_cs_n,
  input  wire        i_spi_sck,
  input  wire        i_spi_mosi,
  output reg         o_spi_miso,
  output reg         o_spi_miso_oe_n,
  output wire        o_event_pin_one
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [47:0] mem [0:31];        // Sample set slots
  reg  [4:0]  wr_ptr;            // Next slot to write
  reg  [4:0]  rd_ptr;            // Oldest unread slot
  reg  [5:0]  unread_count;      // Unread sets, 0..32
  reg  [47:0] last_set;          // Output registers when nothing unread
  reg         fill_done;         // Fill mode reached full
  reg         frozen;            // Trigger mode stopped
  reg         post_taken;        // Extra post-trigger set already taken
  reg  [7:0]  route_reg;         // Pin routing bits
  reg  [7:0]  buffer_enable_control;
  reg  [7:0]  buffer_mode_control;
  reg  [7:0]  event_generator_config;
  reg         ia1;               // Latched active bit of generator one
  reg  [1:0]  ia_clr_cnt;        // Ticks left before the active bit drops
  reg         ia_clr_pend;       // Clear of the active bit pending
  // Serial slave state
  reg  [2:0]  cs_sy;             // cs_n synchroniser plus history
  reg  [2:0]  sck_sy;            // sck synchroniser plus edge history
  reg  [1:0]  mosi_sy;           // mosi synchroniser
  reg  [2:0]  bit_cnt;           // Bit within current byte
  reg  [7:0]  shift_in;          // Incoming byte
  reg  [7:0]  shift_out;         // Transmit byte
  reg         have_cmd;          // Command byte already taken
  reg         cmd_rd;            // Transfer is a read
  reg         cmd_inc;           // Auto-increment enabled
  reg  [5:0]  addr;              // Current register address
  reg         set_read_evt;      // Last output byte just read
  reg         src_read_evt;      // Event source register just read
  reg  [7:0]  rd_data;           // Register read mux
  reg  [5:0]  next_addr;         // Address after the current byte
  reg         wr;                // Append set
  reg         ovw;               // Overwrite oldest set
  reg         next_frozen;
  reg         next_post;
  wire [47:0] stg_data;
  wire        stg_valid;
  wire        tick_pop;
  wire        buf_en;
  wire [1:0]  buffer_mode_field;
  wire        source_pick_bit;
  wire [4:0]  watermark_level;
  wire        active;
  wire        full;
  wire        rd_set;
  wire        trig;
  wire        overrun_flag;
  wire        level_reached_flag;
  wire        empty_flag;
  wire [4:0]  fss;
  wire [7:0]  status;
  wire [47:0] view;
  wire        sck_rise;
  wire        sck_fall;
  wire        byte_done;
  wire [7:0]  byte_in;

  ////////////////////////////////////////////////////////////////////////
  // Staging FIFO: drained once per rate tick, so bursts from the source
  // are absorbed and a slow tick really back-pressures the source
  sfm_stage_fifo #(
    .WIDTH (`SFM_SET_BITS),
    .DEPTH (STAGE_DEPTH),
    .AW    (STAGE_AW)
  ) u_stage (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_sample_valid),
    .o_in_ready  (o_sample_ready),
    .i_in_data   (i_sample_data),
    .o_out_valid (stg_valid),
    .i_out_ready (i_sample_rate_tick),
    .o_out_data  (stg_data)
  );
  assign tick_pop = i_sample_rate_tick && stg_valid;

  ////////////////////////////////////////////////////////////////////////
  // Field decode and status
  assign buf_en            = buffer_enable_control[`SFM_BIT_BUF_EN];
  assign buffer_mode_field = buffer_mode_control[7:6];                 // [RL3]
  assign source_pick_bit   = buffer_mode_control[`SFM_BIT_PICK];
  assign watermark_level   = buffer_mode_control[4:0];
  assign active = buf_en && (buffer_mode_field != `SFM_MODE_BYPASS);
  assign full   = (unread_count == `SFM_SLOTS);
  assign rd_set = set_read_evt && active && (unread_count != 6'h00);  // [RL13]
  // Source is the active bit, not the pin, so routing is irrelevant
  assign trig   = source_pick_bit ? i_gen2_active : ia1;              // [RL15] [RL16]
  assign overrun_flag       = full;                                    // [RL6] [RL8]
  assign level_reached_flag = (unread_count > {1'b0, watermark_level}); // [RL23]
  assign empty_flag = (unread_count == 6'h00);
  assign fss = full ? `SFM_FSS_FULL : unread_count[4:0];               // [RL25]
  // Bypass forces the fixed empty pattern [RL24]; full fill reads 0xDF [RL4]
  assign status = (buffer_mode_field == `SFM_MODE_BYPASS) ? `SFM_STATUS_BYPASS :
                  {level_reached_flag, overrun_flag, empty_flag, fss};
  // Output registers show the oldest unread set, else the last one loaded
  assign view = (active && !empty_flag) ? mem[rd_ptr] : last_set;      // [RL7] [RL2]
  assign o_event_pin_one = (route_reg[`SFM_BIT_RT_OVR] && overrun_flag) ||   // [RL5]
                           (route_reg[`SFM_BIT_RT_WTM] && level_reached_flag);

  ////////////////////////////////////////////////////////////////////////
  // Write decision per rate tick, by mode
  always @* begin
    wr          = 1'b0;
    ovw         = 1'b0;
    next_frozen = frozen;
    next_post   = post_taken;
    if (!trig) begin
      next_frozen = 1'b0;                                              // [RL18]
      next_post   = 1'b0;
    end
    if (active && tick_pop) begin
      case (buffer_mode_field)
        `SFM_MODE_FILL: begin
          // Once full, stays stopped until bypass
          if (!fill_done && !full) begin
            wr = 1'b1;                                                 // [RL1] [RL6]
          end
        end
        `SFM_MODE_STREAM: begin
          if (!full || rd_set) begin
            wr = 1'b1;                                                 // [RL12]
          end else begin
            ovw = 1'b1;                                                // [RL10]
          end
        end
        `SFM_MODE_TRIG: begin
          if (frozen && trig) begin
            wr = 1'b0;
          end else if (full && !rd_set && trig) begin
            // Both flags high: take one more set, then freeze      [RL17]
            if (post_taken) begin
              next_frozen = 1'b1;                                      // [RL14]
            end else begin
              ovw       = 1'b1;                                        // [RL20]
              next_post = 1'b1;
            end
          end else if (full && !rd_set) begin
            ovw = 1'b1;
          end else begin
            wr = 1'b1;
            // Trigger seen while filling: stop as soon as full   [RL21]
            if (trig) begin
              next_post = 1'b1;
            end
          end
        end
        default: wr = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slot storage; an overwrite reuses the oldest slot in place
  always @(posedge i_clk_sys) begin
    if (wr || ovw) begin
      mem[wr_ptr] <= stg_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pointers, count and mode state
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr       <= 5'h00;
      rd_ptr       <= 5'h00;
      unread_count <= 6'h00;
      last_set     <= 48'h0;
      fill_done    <= 1'b0;
      frozen       <= 1'b0;
      post_taken   <= 1'b0;
    end else if (buf_en && buffer_mode_field == `SFM_MODE_BYPASS) begin
      // Clears content, keeps outputs frozen                     [RL9] [RL24]
      wr_ptr       <= 5'h00;
      rd_ptr       <= 5'h00;
      unread_count <= 6'h00;
      fill_done    <= 1'b0;
      frozen       <= 1'b0;
      post_taken   <= 1'b0;
    end else begin
      frozen     <= next_frozen;
      post_taken <= next_post;
      if (wr || ovw) begin
        wr_ptr <= wr_ptr + 5'h01;
      end
      if (rd_set || ovw) begin
        rd_ptr <= rd_ptr + 5'h01;
      end
      // Write and read together cancel out                     [RL26] [RL25]
      unread_count <= unread_count + {5'h00, wr} - {5'h00, rd_set};
      if (active && buffer_mode_field == `SFM_MODE_FILL && full) begin
        fill_done <= 1'b1;                                             // [RL6]
      end
      if (rd_set) begin
        last_set <= mem[rd_ptr];                                       // [RL13]
      end else if (!buf_en && tick_pop) begin
        // Buffer off: output registers track the live sample
        last_set <= stg_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Generator one active bit: latched on event, dropped two ticks after
  // the source register is read. A new event wins over the clear.
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ia1         <= 1'b0;
      ia_clr_cnt  <= 2'h0;
      ia_clr_pend <= 1'b0;
    end else begin
      if (src_read_evt) begin
        ia_clr_pend <= 1'b1;
        ia_clr_cnt  <= `SFM_IA_CLR_PERIODS;                            // [RL19]
      end else if (ia_clr_pend && i_sample_rate_tick) begin
        if (ia_clr_cnt == 2'h1) begin
          ia_clr_pend <= 1'b0;
        end
        ia_clr_cnt <= ia_clr_cnt - 2'h1;
      end
      if (i_gen1_event) begin
        ia1 <= 1'b1;
      end else if (ia_clr_pend && i_sample_rate_tick && ia_clr_cnt == 2'h1) begin
        ia1 <= 1'b0;                                                   // [RL19]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read mux
  always @* begin
    case (addr)
      `SFM_ADDR_ROUTE:   rd_data = route_reg;
      `SFM_ADDR_ENABLE:  rd_data = buffer_enable_control;
      6'h28:             rd_data = view[7:0];
      6'h29:             rd_data = view[15:8];
      6'h2A:             rd_data = view[23:16];
      6'h2B:             rd_data = view[31:24];
      6'h2C:             rd_data = view[39:32];
      `SFM_ADDR_OUT_LAST: rd_data = view[47:40];
      `SFM_ADDR_MODE:    rd_data = buffer_mode_control;
      `SFM_ADDR_STATUS:  rd_data = status;
      `SFM_ADDR_GEN_CFG: rd_data = event_generator_config;
      `SFM_ADDR_EVT_SRC: rd_data = {1'b0, ia1, 6'h00};
      default:           rd_data = 8'h00;
    endcase
  end

  // Auto-increment wraps inside the output block for burst readout
  always @* begin
    if (addr == `SFM_ADDR_OUT_LAST) begin
      next_addr = `SFM_ADDR_OUT_FIRST;
    end else begin
      next_addr = addr + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial pin synchronisers; logic reads the second stage, and the third for sck edges
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_sy   <= 3'h7;
      sck_sy  <= 3'h7;
      mosi_sy <= 2'h0;
    end else begin
      cs_sy   <= {cs_sy[1:0], i_spi_cs_n};
      sck_sy  <= {sck_sy[1:0], i_spi_sck};
      mosi_sy <= {mosi_sy[0], i_spi_mosi};
    end
  end
  assign sck_rise  = !cs_sy[1] && sck_sy[1] && !sck_sy[2];
  assign sck_fall  = !cs_sy[1] && !sck_sy[1] && sck_sy[2];
  assign byte_done = sck_rise && (bit_cnt == 3'h7);
  assign byte_in   = {shift_in[6:0], mosi_sy[1]};

  ////////////////////////////////////////////////////////////////////////
  // Serial slave: command byte, then data bytes. Each read byte is loaded
  // on its own first fall, so a byte the host never clocks has no effect.
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt                <= 3'h0;
      shift_in               <= 8'h00;
      shift_out              <= 8'h00;
      have_cmd               <= 1'b0;
      cmd_rd                 <= 1'b0;
      cmd_inc                <= 1'b0;
      addr                   <= 6'h00;
      set_read_evt           <= 1'b0;
      src_read_evt           <= 1'b0;
      o_spi_miso             <= 1'b0;
      o_spi_miso_oe_n        <= 1'b1;
      route_reg              <= 8'h00;
      buffer_enable_control  <= 8'h00;
      buffer_mode_control    <= 8'h00;
      event_generator_config <= 8'h00;
    end else begin
      set_read_evt <= 1'b0;
      src_read_evt <= 1'b0;
      if (cs_sy[1]) begin
        // Deselected: abandon any partial byte, release the pin
        bit_cnt         <= 3'h0;
        have_cmd        <= 1'b0;
        o_spi_miso_oe_n <= 1'b1;
      end else begin
        if (sck_rise) begin
          shift_in <= byte_in;
          bit_cnt  <= bit_cnt + 3'h1;
        end
        if (byte_done && !have_cmd) begin
          have_cmd <= 1'b1;
          cmd_rd   <= byte_in[`SFM_BIT_CMD_RD];
          cmd_inc  <= byte_in[`SFM_BIT_CMD_INC];
          addr     <= byte_in[5:0];
        end else if (byte_done && cmd_rd) begin
          if (cmd_inc) begin
            addr <= next_addr;
          end
        end else if (byte_done) begin
          case (addr)
            `SFM_ADDR_ROUTE:   route_reg              <= byte_in;
            `SFM_ADDR_ENABLE:  buffer_enable_control  <= byte_in;
            `SFM_ADDR_MODE:    buffer_mode_control    <= byte_in;
            `SFM_ADDR_GEN_CFG: event_generator_config <= byte_in;
            default:           route_reg              <= route_reg;
          endcase
          if (cmd_inc) begin
            addr <= addr + 6'h01;
          end
        end
        if (sck_fall) begin
          o_spi_miso      <= shift_out[7];
          shift_out       <= {shift_out[6:0], 1'b0};
          o_spi_miso_oe_n <= !(have_cmd && cmd_rd);
          // First fall of a read byte copies the addressed register to the
          // transmit buffer; the last output byte then shifts a set [RL13]
          if (have_cmd && cmd_rd && bit_cnt == 3'h0) begin
            o_spi_miso   <= rd_data[7];
            shift_out    <= {rd_data[6:0], 1'b0};
            set_read_evt <= (addr == `SFM_ADDR_OUT_LAST);              // [RL8]
            src_read_evt <= (addr == `SFM_ADDR_EVT_SRC);                // [RL19]
          end
        end
      end
    end
  end
endmodule

/* File: testbench/sfm_checker.sv */
/* Port-level checker for the sample buffer block.
   Assumes it is bound onto sfm_top and the host keeps mode 3 timing. */
`timescale 1ns/1ps
module sfm_checker (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_sample_rate_tick,
  input wire i_sample_valid,
  input wire o_sample_ready,
  input wire i_spi_cs_n,
  input wire i_spi_sck,
  input wire o_spi_miso,
  input wire o_spi_miso_oe_n,
  input wire o_event_pin_one
);
  reg [3:0] hi_cnt; // Cycles the serial clock pin has stayed high

  ////////////////////////////////////////////////////////////////////////
  // Helper: saturating count, so a late data change shows up
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n)
      hi_cnt <= 4'h0;
    else if (!i_spi_sck)
      hi_cnt <= 4'h0;
    else if (hi_cnt != 4'hF)
      hi_cnt <= hi_cnt + 4'h1;
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Serial output side
  property p_oe_idle; i_spi_cs_n [*6] |-> o_spi_miso_oe_n; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("miso driven while idle");
  property p_oe_fell; $fell(o_spi_miso_oe_n) |-> !i_spi_cs_n && !i_spi_sck; endproperty
  a_oe_fell: assert property (p_oe_fell) else $error("drive start off a fall");
  property p_oe_hold; $fell(o_spi_miso_oe_n) |=> !o_spi_miso_oe_n [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("drive dropped early");
  property p_oe_rel; $rose(o_spi_miso_oe_n) |-> i_spi_cs_n; endproperty
  a_oe_rel: assert property (p_oe_rel) else $error("drive released in frame");
  property p_miso_edge;
    $changed(o_spi_miso) && !o_spi_miso_oe_n && !i_spi_cs_n |-> hi_cnt < 4'h3;
  endproperty
  a_miso_edge: assert property (p_miso_edge) else $error("miso moved late");

  ////////////////////////////////////////////////////////////////////////
  // Staging and event pin: change only for a cause
  property p_rdy_hold;
    !o_sample_ready && !i_sample_rate_tick && !$past(i_sample_rate_tick) |=> !o_sample_ready;
  endproperty
  a_rdy_hold: assert property (p_rdy_hold) else $error("ready rose without pop");
  property p_rdy_fell; $fell(o_sample_ready) |-> $past(i_sample_valid); endproperty
  a_rdy_fell: assert property (p_rdy_fell) else $error("ready fell without push");
  property p_pin_cause;
    $changed(o_event_pin_one) |-> $past(i_sample_rate_tick) || $past(i_sample_rate_tick, 2)
      || !$past(i_spi_cs_n, 5) || !i_spi_cs_n;
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin moved uncaused");
endmodule

bind sfm_top sfm_checker i_sfm_checker (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_sample_rate_tick(i_sample_rate_tick), .i_sample_valid(i_sample_valid),
  .o_sample_ready(o_sample_ready), .i_spi_cs_n(i_spi_cs_n), .i_spi_sck(i_spi_sck),
  .o_spi_miso(o_spi_miso), .o_spi_miso_oe_n(o_spi_miso_oe_n),
  .o_event_pin_one(o_event_pin_one));

/* File: testbench/sfm_host_model.sv */
/* Host model: serial register master, mode 3, MSB first, 80 ns clock.
   Assumes the block's serial slave at the far end; bytes land in rbuf. */
`timescale 1ns/1ps
module sfm_host_model (
  output reg  o_spi_cs_n,
  output reg  o_spi_sck,
  output reg  o_spi_mosi,
  input  wire i_spi_miso
);
  reg [7:0] rbuf [0:191]; // Bytes returned by the last access

  initial begin
    o_spi_cs_n = 1'b1;
    o_spi_sck  = 1'b1;
    o_spi_mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One byte: change on the fall, take miso on the rise
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      o_spi_sck  = 1'b0;
      o_spi_mosi = tx[i];
      #40;
      o_spi_sck  = 1'b1;
      rx[i]      = i_spi_miso;
      #40;
    end
  endtask

  // Whole frame; a full 192 byte burst fits well inside one tick period
  task access(input [7:0] cmd, input [7:0] wd, input integer n);
    integer   k;
    reg [7:0] d;
    o_spi_cs_n = 1'b0;
    #40;
    xfer(cmd, d);
    for (k = 0; k < n; k = k + 1) begin
      xfer(wd, d);
      rbuf[k] = d;
    end
    #40;
    o_spi_cs_n = 1'b1;
    // Released line must not keep its last level
    o_spi_mosi = ~o_spi_mosi;
    #200;
  endtask
endmodule

/* File: testbench/sfm_top_tb.sv */
/* Bench for the sample buffer block: a table of mode runs, then hand tests.
   Assumes the host model drives the serial pins and the checker is bound. */
`timescale 1ns/1ps
module sfm_top_tb;
  reg         i_clk_sys;
  reg         i_rst_n;
  reg         tick;
  reg         valid;
  reg         gen1;        // Generator one event
  reg         gen2;
  reg  [47:0] data;
  reg  [7:0]  sn;          // Number of the next set, also its byte 0
  reg  [7:0]  base;        // Number of the set expected oldest
  reg  [23:0] rows [0:5];  // Mode byte, tick count, expected status
  wire        ready;
  wire        cs_n;
  wire        sck;
  wire        mosi;
  wire        miso;
  wire        oe_n;
  wire        pin;
  integer     mismatches;
  integer     checks_done;
  integer     j;

  sfm_top i_sfm_top (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sample_rate_tick(tick),
    .i_sample_valid(valid), .o_sample_ready(ready), .i_sample_data(data),
    .i_gen1_event(gen1), .i_gen2_active(gen2), .i_spi_cs_n(cs_n), .i_spi_sck(sck),
    .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe_n(oe_n), .o_event_pin_one(pin));
  sfm_host_model i_sfm_host_model (.o_spi_cs_n(cs_n), .o_spi_sck(sck), .o_spi_mosi(mosi),
    .i_spi_miso(miso));

  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input [5:0] a, input [7:0] v);
    i_sfm_host_model.access({2'h0, a}, v, 1);
  endtask
  // Reads always auto-increment, wrapping the output bytes
  task rd(input [5:0] a, input integer n);
    i_sfm_host_model.access({2'h3, a}, 8'h00, n);
  endtask
  // Read n bytes from a, compare the first one
  task rdc(input [5:0] a, input integer n, input [7:0] exp);
    rd(a, n);
    chk(i_sfm_host_model.rbuf[0], exp);
  endtask
  task pulse;
    @(posedge i_clk_sys);
    #1 tick = 1'b1;
    @(posedge i_clk_sys);
    #1 tick = 1'b0;
  endtask
  // Offer one set, wait for acceptance, then one rate tick
  task feed(input integer n);
    integer m;
    integer k;
    for (m = 0; m < n; m = m + 1) begin
      @(posedge i_clk_sys);
      #1 valid = 1'b1;
      data = {8'h5A, 32'h0, sn};
      k = 0;
      while (ready !== 1'b1 && k < 40) begin
        @(posedge i_clk_sys);
        #1 k = k + 1;
      end
      if (k == 40) begin
        mismatches = mismatches + 1;
        wrap_up;
      end
      @(posedge i_clk_sys);
      #1 valid = 1'b0;
      pulse;
      sn = sn + 8'h01;
    end
  endtask
  task mode(input [7:0] v);
    wr(6'h2E, 8'h0A);
    wr(6'h2E, v);
    base = sn;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_rst_n = 1'b0;
    tick = 1'b0;
    valid = 1'b0;
    gen1 = 1'b0;
    gen2 = 1'b0;
    data = 48'h0;
    sn = 8'h00;
    mismatches = 0;
    checks_done = 0;
    rows[0] = 24'h4A0505;
    rows[1] = 24'h4A21DF;
    rows[2] = 24'h8A0B8B;
    rows[3] = 24'h8A28DF;
    rows[4] = 24'hCA28DF;
    rows[5] = 24'h0A0320;
    repeat (16) @(posedge i_clk_sys);
    chk({5'h00, ready, oe_n, pin}, 8'h06);
    #1 i_rst_n = 1'b1;
    repeat (4) @(posedge i_clk_sys);
    #1 rdc(6'h2F, 1, 8'h20);
    // Enable alone must freeze the outputs at the last set
    feed(1);
    base = sn - 8'h01;
    wr(6'h24, 8'h40);
    feed(2);
    rdc(6'h28, 1, base);
    for (j = 0; j < 6; j = j + 1) begin
      mode(rows[j][23:16]);
      feed(rows[j][15:8]);
      rdc(6'h2F, 1, rows[j][7:0]);
    end
    // Staging fills to refusal while no tick drains it
    mode(8'h4A);
    @(posedge i_clk_sys);
    #1 valid = 1'b1;
    for (j = 0; j < 16; j = j + 1) begin
      data = {8'h5A, 32'h0, sn};
      @(posedge i_clk_sys);
      #1 sn = sn + 8'h01;
    end
    chk({7'h00, ready}, 8'h00);
    valid = 1'b0;
    repeat (16) pulse;
    rdc(6'h2F, 1, 8'h90);
    rdc(6'h28, 12, base);
    chk(i_sfm_host_model.rbuf[5], 8'h5A);
    chk(i_sfm_host_model.rbuf[6], base + 8'h01);
    rdc(6'h2F, 1, 8'h8E);
    // Full fill: pin routing, overrun clear, stop, full readout
    mode(8'h4A);
    feed(33);
    chk({7'h00, pin}, 8'h00);
    wr(6'h22, 8'h02);
    chk({7'h00, pin}, 8'h01);
    rdc(6'h28, 6, base);
    rdc(6'h2F, 1, 8'h9F);
    chk({7'h00, pin}, 8'h00);
    feed(2);
    rdc(6'h2F, 1, 8'h9F);
    rd(6'h28, 186);
    for (j = 0; j < 31; j = j + 1)
      chk(i_sfm_host_model.rbuf[6 * j], base + j[7:0] + 8'h01);
    rdc(6'h2F, 1, 8'h20);
    // Circular overwrite drops the two oldest sets
    mode(8'h8A);
    feed(34);
    rdc(6'h28, 6, base + 8'h02);
    // Trigger from generator two while full: one more set, then freeze
    mode(8'hEA);
    feed(40);
    gen2 = 1'b1;
    feed(4);
    rdc(6'h28, 6, base + 8'h09);
    // Generator one latches; a source read drops it at the second tick
    gen1 = 1'b1;
    pulse;
    gen1 = 1'b0;
    rdc(6'h31, 1, 8'h40);
    pulse;
    rdc(6'h31, 1, 8'h40);
    repeat (2) pulse;
    rdc(6'h31, 1, 8'h00);
    wrap_up;
  end
endmodule
